// ==== core/crs_regs.vh ====
// register map, field positions, reset values and timing constants of the routine scheduler
`ifndef CRS_REGS_VH
`define CRS_REGS_VH

// ==========================================================================
// register byte offsets (bits [7:0] of the wishbone address)
`define CRS_ADDR_CTRL        8'h00
`define CRS_ADDR_TIMING      8'h04
`define CRS_ADDR_PERIOD      8'h08
`define CRS_ADDR_STEPCFG     8'h0C
`define CRS_ADDR_STATUS      8'h10

// ==========================================================================
// control register fields
`define CRS_CTRL_SOC         0
`define CRS_CTRL_CYCLIC_EN   1
`define CRS_CTRL_BAL_HOLD    2
`define CRS_CTRL_TIM_HOLD    3
`define CRS_CTRL_REF_EN      4
`define CRS_CTRL_REF_DYN     5
`define CRS_CTRL_BAL_REQ     6

// ==========================================================================
// timing register fields, all in timebase ticks
`define CRS_TIM_SOC_LSB      0
`define CRS_TIM_CYC_LSB      8
`define CRS_TIM_SETTLE_LSB   16
`define CRS_TIM_CUR_LSB      24
`define CRS_TIM_FIELD_W      8

// ==========================================================================
// optional step period selects, three bits each
`define CRS_SEL_W            3
`define CRS_SEL_AUX_LSB      0
`define CRS_SEL_CTERM_LSB    3
`define CRS_SEL_BTERM_LSB    6
`define CRS_SEL_HARDWARE_SELF_CHECK_STEP_LSB     9

// ==========================================================================
// status register fields
`define CRS_STAT_ACTIVE      0
`define CRS_STAT_OVERRUN     1

// ==========================================================================
// reset values
`define CRS_CTRL_RST         32'h00000000
`define CRS_TIMING_RST       32'h00000A0A
`define CRS_PERIOD_RST       32'h000003E8
`define CRS_STEPCFG_RST      32'h00000000

// ==========================================================================
// timebase
`define CRS_CLK_PERIOD_NS    10
`define CRS_TICK_NS          1000
`define CRS_TICK_CYCLES      (`CRS_TICK_NS / `CRS_CLK_PERIOD_NS)

`endif

// ==== core/crs_step_timer.v ====
// loadable down counter that advances on the timebase tick
module crs_step_timer #(
   parameter W = 16
) (
   input  wire         clk_i,
   input  wire         rst_i,
   input  wire         load_i,
   input  wire [W-1:0] load_val_i,
   input  wire         tick_i,
   output wire         zero_o
);

   reg [W-1:0] count;

   // ==========================================================================
   // counter
   always @(posedge clk_i) begin
      if (rst_i) begin
         count <= {W{1'b0}};
      end else if (load_i) begin
         count <= load_val_i;
      end else if (tick_i && (count != {W{1'b0}})) begin
         count <= count - {{(W-1){1'b0}}, 1'b1};
      end
   end

   assign zero_o = (count == {W{1'b0}});

endmodule // crs_step_timer

// ==== core/crs_period_match.v ====
// decides per optional step whether it runs in the current period
module crs_period_match #(
   parameter NSTEP = 4,
   parameter SELW  = 3,
   parameter CNTW  = 16
) (
   input  wire [NSTEP*SELW-1:0] sel_i,
   input  wire [CNTW-1:0]       count_i,
   output wire [NSTEP-1:0]      run_o
);

   localparam [CNTW-1:0] ONE = {{(CNTW-1){1'b0}}, 1'b1};

   // ==========================================================================
   // per step: code 0 skips, code c runs every 2**c periods
   genvar g;
   generate
      for (g = 0; g < NSTEP; g = g + 1) begin : g_step
         wire [SELW-1:0] sel  = sel_i[g*SELW +: SELW];
         wire [CNTW-1:0] mask = (ONE << sel) - ONE;
         assign run_o[g] = (sel != {SELW{1'b0}}) && ((count_i & mask) == {CNTW{1'b0}});
      end
   endgenerate

endmodule // crs_period_match

// ==== core/crs_sched.v ====
// voltage conversion routine scheduler with wishbone register slave
//
// Contract
// - step duration from on-demand field, or cyclic field for cyclic runs.
// - active phase length follows scheduled steps and their durations.
// - active-phase flag high for the whole active phase, any mode.
// - after active phase, idle until the routine period ends.
// - active phase longer than period sets overrun latch; runs back to back.
// - period counter increments by one at each period end.
// - each optional step has a period select; code 010 means every 4.
// - cell and stack steps always run.
// - mandatory steps pause balancing only when balance auto-hold is 1.
// - optional steps can be skipped or run periodically.
// - auxiliary input step leaves balancing running.
// - cell-terminal, balance-terminal, self-check steps always stop balancing.
// - paused balancing freezes balance timer when timer auto-hold is 1.
// - with balance auto-hold 1, each trigger waits the settling delay before the routine.
// - settling delay only when balance auto-hold is 1.
// - cell step may wait further to align with next current sample.
// - dynamic regulator on from trigger until self-check ends; enable alone always on.
// - one routine at a time; host must not mix modes while active.
// - fault override aborts the routine and returns it to idle.
`include "crs_regs.vh"

module crs_sched #(
   parameter TICK_CYCLES = `CRS_TICK_CYCLES,
   parameter CNTW        = 16
) (
   input  wire        clk_i,
   input  wire        rst_i,
   input  wire        wb_cyc_i,
   input  wire        wb_stb_i,
   input  wire        wb_we_i,
   input  wire [31:0] wb_adr_i,
   input  wire [3:0]  wb_sel_i,
   input  wire [31:0] wb_dat_i,
   output reg  [31:0] wb_dat_o,
   output reg         wb_ack_o,
   input  wire        fault_override_i,
   output reg         active_phase_o,
   output reg         balance_enable_o,
   output reg         balance_timer_run_o,
   output reg         ref_regulator_on_o,
   output reg  [2:0]  step_o,
   output reg         step_valid_o
);

   localparam [2:0] ST_IDLE   = 3'h0;
   localparam [2:0] ST_SETTLE = 3'h1;
   localparam [2:0] ST_ALIGN  = 3'h2;
   localparam [2:0] ST_LOAD   = 3'h3;
   localparam [2:0] ST_RUN    = 3'h4;

   localparam [2:0] STEP_CELL  = 3'h0;
   localparam [2:0] STEP_STACK = 3'h1;
   localparam [2:0] STEP_CTERM = 3'h3;
   localparam [2:0] STEP_LAST  = 3'h5;

   localparam TW = `CRS_TIM_FIELD_W;

   // ==========================================================================
   // registers and state
   reg  [31:0]     ctrl;
   reg  [31:0]     timing;
   reg  [31:0]     period;
   reg  [31:0]     stepcfg;
   reg             overrun_latch;
   reg  [2:0]      state;
   reg  [2:0]      step_idx;
   reg  [5:0]      run_mask;
   reg             cyc_mode;
   reg             cyc_running;
   reg             cyc_lock;
   reg             pend_start;
   reg  [15:0]     per_elapsed;
   reg  [CNTW-1:0] period_counter;
   reg  [TW-1:0]   cur_cnt;
   reg  [15:0]     tick_div;
   reg             tick;
   reg             ovr_meta;
   reg             ovr_sync;
   reg             soc_pulse;

   wire            wb_req = wb_cyc_i && wb_stb_i && !wb_ack_o;
   wire            wb_wr  = wb_req && wb_we_i;
   wire [7:0]      adr    = wb_adr_i[7:0];
   wire            active = (state != ST_IDLE);
   wire            bal_hold = ctrl[`CRS_CTRL_BAL_HOLD];
   wire            tim_hold = ctrl[`CRS_CTRL_TIM_HOLD];
   wire            cyc_en   = ctrl[`CRS_CTRL_CYCLIC_EN];
   wire [TW-1:0]   dur_soc  = timing[`CRS_TIM_SOC_LSB +: TW];
   wire [TW-1:0]   dur_cyc  = timing[`CRS_TIM_CYC_LSB +: TW];
   wire [TW-1:0]   settle   = timing[`CRS_TIM_SETTLE_LSB +: TW];
   wire [TW-1:0]   cur_step = timing[`CRS_TIM_CUR_LSB +: TW];
   wire [3:0]      opt_run;
   wire            tmr_zero;
   reg             tmr_load;
   reg  [15:0]     tmr_val;

   // period ends on the tick that reaches the programmed length
   wire            period_end = cyc_running && tick && ((per_elapsed + 16'h0001) >= period[15:0]);
   wire            start_cyc  = !active && !ovr_sync && cyc_en && !cyc_lock && (pend_start || !cyc_running);
   // on-demand ignored while cyclic is enabled or a routine is already running
   wire            start_soc  = !active && !ovr_sync && !cyc_en && soc_pulse;
   wire            finishing  = ((state == ST_RUN) && tmr_zero && (step_idx == STEP_LAST)) ||
                                ((state == ST_LOAD) && !run_mask[step_idx] && (step_idx == STEP_LAST));

   function [31:0] bytewrite;
      input [31:0] old;
      input [31:0] d;
      input [3:0]  sel;
      integer      i;
      begin
         bytewrite = old;
         for (i = 0; i < 4; i = i + 1) begin
            if (sel[i]) begin
               bytewrite[i*8 +: 8] = d[i*8 +: 8];
            end
         end
      end
   endfunction

   // ==========================================================================
   // timebase divider and override synchroniser
   always @(posedge clk_i) begin
      if (rst_i) begin
         tick_div <= 16'h0000;
         tick     <= 1'b0;
         ovr_meta <= 1'b0;
         ovr_sync <= 1'b0;
      end else begin
         ovr_meta <= fault_override_i;
         ovr_sync <= ovr_meta;
         if (tick_div == TICK_CYCLES[15:0] - 16'h0001) begin
            tick_div <= 16'h0000;
            tick     <= 1'b1;
         end else begin
            tick_div <= tick_div + 16'h0001;
            tick     <= 1'b0;
         end
      end
   end

   // free running current sample phase, used to align the cell step
   always @(posedge clk_i) begin
      if (rst_i) begin
         cur_cnt <= {TW{1'b0}};
      end else if (tick) begin
         if (cur_cnt == {TW{1'b0}}) begin
            cur_cnt <= (cur_step == {TW{1'b0}}) ? {TW{1'b0}} : cur_step - {{(TW-1){1'b0}}, 1'b1};
         end else begin
            cur_cnt <= cur_cnt - {{(TW-1){1'b0}}, 1'b1};
         end
      end
   end

   // ==========================================================================
   // wishbone slave: one wait state, unmapped reads return zero
   always @(posedge clk_i) begin
      if (rst_i) begin
         ctrl      <= `CRS_CTRL_RST;
         timing    <= `CRS_TIMING_RST;
         period    <= `CRS_PERIOD_RST;
         stepcfg   <= `CRS_STEPCFG_RST;
         soc_pulse <= 1'b0;
         wb_ack_o  <= 1'b0;
         wb_dat_o  <= 32'h00000000;
      end else begin
         wb_ack_o  <= wb_req;
         soc_pulse <= 1'b0;
         if (wb_wr) begin
            case (adr)
               `CRS_ADDR_CTRL: begin
                  ctrl      <= bytewrite(ctrl, wb_dat_i, wb_sel_i) & 32'h0000007E;
                  soc_pulse <= wb_sel_i[0] && wb_dat_i[`CRS_CTRL_SOC];
               end
               `CRS_ADDR_TIMING:  timing  <= bytewrite(timing, wb_dat_i, wb_sel_i);
               `CRS_ADDR_PERIOD:  period  <= bytewrite(period, wb_dat_i, wb_sel_i) & 32'h0000FFFF;
               `CRS_ADDR_STEPCFG: stepcfg <= bytewrite(stepcfg, wb_dat_i, wb_sel_i) & 32'h00000FFF;
               default: begin
               end
            endcase
         end
         if (wb_req && !wb_we_i) begin
            case (adr)
               `CRS_ADDR_CTRL:    wb_dat_o <= ctrl | {31'h0, active && !cyc_mode};
               `CRS_ADDR_TIMING:  wb_dat_o <= timing;
               `CRS_ADDR_PERIOD:  wb_dat_o <= period;
               `CRS_ADDR_STEPCFG: wb_dat_o <= stepcfg;
               `CRS_ADDR_STATUS:  wb_dat_o <= {period_counter[15:0], 5'h00, step_idx, 3'h0, ref_regulator_on_o,
                                               !balance_timer_run_o && ctrl[`CRS_CTRL_BAL_REQ],
                                               !balance_enable_o && ctrl[`CRS_CTRL_BAL_REQ],
                                               overrun_latch, active};
               default:           wb_dat_o <= 32'h00000000;
            endcase
         end
      end
   end

   // ==========================================================================
   // overrun latch: set wins over the write-one clear
   always @(posedge clk_i) begin
      if (rst_i) begin
         overrun_latch <= 1'b0;
      end else if (period_end && active && !finishing) begin
         overrun_latch <= 1'b1;
      end else if (wb_wr && (adr == `CRS_ADDR_STATUS) && wb_sel_i[0] && wb_dat_i[`CRS_STAT_OVERRUN]) begin
         overrun_latch <= 1'b0;
      end
   end

   // ==========================================================================
   // period timing and counter
   always @(posedge clk_i) begin
      if (rst_i) begin
         per_elapsed    <= 16'h0000;
         period_counter <= {CNTW{1'b0}};
         pend_start     <= 1'b0;
         cyc_running    <= 1'b0;
         cyc_lock       <= 1'b0;
      end else begin
         if (!cyc_en) begin
            cyc_lock <= 1'b0;
         end else if (ovr_sync && cyc_running) begin
            cyc_lock <= 1'b1;
         end
         if (!cyc_en || ovr_sync) begin
            cyc_running <= 1'b0;
            pend_start  <= 1'b0;
            per_elapsed <= 16'h0000;
         end else if (start_cyc) begin
            cyc_running <= 1'b1;
            pend_start  <= 1'b0;
            if (!cyc_running) begin
               per_elapsed <= 16'h0000;
            end
         end else if (period_end) begin
            per_elapsed <= 16'h0000;
            pend_start  <= 1'b1;
         end else if (cyc_running && tick) begin
            per_elapsed <= per_elapsed + 16'h0001;
         end
         if (period_end || (finishing && !cyc_mode)) begin
            period_counter <= period_counter + {{(CNTW-1){1'b0}}, 1'b1};
         end
      end
   end

   // ==========================================================================
   // routine sequencer
   always @* begin
      tmr_load = 1'b0;
      tmr_val  = 16'h0000;
      if ((start_cyc || start_soc) && bal_hold) begin
         tmr_load = 1'b1;
         tmr_val  = {8'h00, settle};
      end else if ((state == ST_LOAD) && run_mask[step_idx]) begin
         tmr_load = 1'b1;
         tmr_val  = {8'h00, cyc_mode ? dur_cyc : dur_soc};
      end
   end

   always @(posedge clk_i) begin
      if (rst_i) begin
         state    <= ST_IDLE;
         step_idx <= STEP_CELL;
         run_mask <= 6'h00;
         cyc_mode <= 1'b0;
      end else if (ovr_sync) begin
         state    <= ST_IDLE;
         step_idx <= STEP_CELL;
      end else begin
         case (state)
            ST_IDLE: begin
               if (start_cyc || start_soc) begin
                  cyc_mode <= start_cyc;
                  run_mask <= {opt_run, 2'b11};
                  step_idx <= STEP_CELL;
                  state    <= bal_hold ? ST_SETTLE : ST_ALIGN;
               end
            end
            ST_SETTLE: begin
               if (tmr_zero) begin
                  state <= ST_ALIGN;
               end
            end
            ST_ALIGN: begin
               // at most one current step of extra wait
               if ((cur_step == {TW{1'b0}}) || (tick && (cur_cnt == {TW{1'b0}}))) begin
                  state <= ST_LOAD;
               end
            end
            ST_LOAD: begin
               if (run_mask[step_idx]) begin
                  state <= ST_RUN;
               end else if (step_idx == STEP_LAST) begin
                  state <= ST_IDLE;
               end else begin
                  step_idx <= step_idx + 3'h1;
               end
            end
            ST_RUN: begin
               if (tmr_zero) begin
                  if (step_idx == STEP_LAST) begin
                     state    <= ST_IDLE;
                     step_idx <= STEP_CELL;
                  end else begin
                     step_idx <= step_idx + 3'h1;
                     state    <= ST_LOAD;
                  end
               end
            end
            default: state <= ST_IDLE;
         endcase
      end
   end

   // ==========================================================================
   // balance, regulator and status outputs
   wire in_step   = (state == ST_LOAD) || (state == ST_RUN);
   wire mand_step = in_step && (step_idx <= STEP_STACK);
   wire hard_stop = in_step && (step_idx >= STEP_CTERM);
   // aux step (index 2) is neither mandatory nor a hard stop, so balancing continues
   wire paused    = hard_stop || (bal_hold && (mand_step || (state == ST_SETTLE) || (state == ST_ALIGN)));
   wire bal_req   = ctrl[`CRS_CTRL_BAL_REQ];

   always @(posedge clk_i) begin
      if (rst_i) begin
         active_phase_o      <= 1'b0;
         balance_enable_o    <= 1'b0;
         balance_timer_run_o <= 1'b0;
         ref_regulator_on_o  <= 1'b0;
         step_o              <= 3'h0;
         step_valid_o        <= 1'b0;
      end else begin
         active_phase_o      <= active;
         balance_enable_o    <= bal_req && !paused;
         balance_timer_run_o <= bal_req && !(paused && tim_hold);
         ref_regulator_on_o  <= ctrl[`CRS_CTRL_REF_EN] && (!ctrl[`CRS_CTRL_REF_DYN] || active);
         step_o              <= step_idx;
         step_valid_o        <= (state == ST_RUN);
      end
   end

   // ==========================================================================
   // submodules
   crs_step_timer #(
      .W (16)
   ) u_timer (
      .clk_i      (clk_i),
      .rst_i      (rst_i),
      .load_i     (tmr_load),
      .load_val_i (tmr_val),
      .tick_i     (tick),
      .zero_o     (tmr_zero)
   );

   crs_period_match #(
      .NSTEP (4),
      .SELW  (`CRS_SEL_W),
      .CNTW  (CNTW)
   ) u_match (
      .sel_i   (stepcfg[11:0]),
      .count_i (period_counter),
      .run_o   (opt_run)
   );

endmodule // crs_sched

// ==== testbench/crs_sched_chk.sv ====
// concurrent checks on the conversion routine scheduler ports
// ==========================================================
// port checker
module crs_sched_chk (
   input wire logic        clk_i,
   input wire logic        rst_i,
   input wire logic        wb_cyc_i,
   input wire logic        wb_stb_i,
   input wire logic        wb_ack_o,
   input wire logic        fault_override_i,
   input wire logic        active_phase_o,
   input wire logic        balance_enable_o,
   input wire logic        balance_timer_run_o,
   input wire logic [2:0]  step_o,
   input wire logic        step_valid_o
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking cb @(posedge clk_i);
   endclocking
   default disable iff (rst_i);
   sequence cell_s;
      step_valid_o && step_o == 3'h0;
   endsequence
   sequence cell_end_s;
      cell_s ##1 !(step_valid_o && step_o == 3'h0);
   endsequence
   sequence stack_s;
      step_valid_o && step_o == 3'h1;
   endsequence
   ack_single_a: assert property (wb_ack_o |=> !wb_ack_o)
      else $error("ack held longer than one cycle");
   ack_latency_a: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
      else $error("ack missing one cycle after request");
   phase_flag_a: assert property (step_valid_o && $past(step_valid_o) |-> active_phase_o)
      else $error("step running outside the active phase");
   term_stop_a: assert property (step_valid_o && step_o >= 3'h3 && $past(step_valid_o && step_o >= 3'h3)
      |-> !balance_enable_o) else $error("balancing left on in a terminal or self-check step");
   timer_hold_a: assert property (balance_enable_o |-> balance_timer_run_o)
      else $error("balance timer frozen while balancing runs");
   fault_abort_a: assert property (fault_override_i [*6] |-> !active_phase_o && !step_valid_o)
      else $error("routine still active under override");
   cell_first_a: assert property (disable iff (rst_i || fault_override_i)
      $rose(active_phase_o) |-> ##[0:1000] cell_s) else $error("cell step missing from run");
   stack_next_a: assert property (disable iff (rst_i || fault_override_i)
      cell_end_s |-> ##[0:4] stack_s) else $error("stack step missing after cell step");
endmodule // crs_sched_chk

bind crs_sched crs_sched_chk crs_sched_chk_inst (.clk_i, .rst_i, .wb_cyc_i, .wb_stb_i, .wb_ack_o, .fault_override_i,
   .active_phase_o, .balance_enable_o, .balance_timer_run_o, .step_o, .step_valid_o);

// ==== testbench/crs_host_model.sv ====
// wishbone host model that issues scheduler commands
// ==========================================================
// host model
module crs_host_model (
   input  wire logic        clk_i,
   input  wire logic [31:0] wb_dat_i,
   input  wire logic        wb_ack_i,
   output logic             wb_cyc_o,
   output logic             wb_stb_o,
   output logic             wb_we_o,
   output logic [31:0]      wb_adr_o,
   output logic [3:0]       wb_sel_o,
   output logic [31:0]      wb_dat_o
);
   timeunit 1ns;
   timeprecision 1ps;
   initial begin
      wb_cyc_o <= 1'b0;
      wb_stb_o <= 1'b0;
      wb_we_o  <= 1'b0;
      wb_adr_o <= 32'h0;
      wb_sel_o <= 4'h0;
      wb_dat_o <= 32'h0;
   end
   // one classic cycle, bounded wait
   task automatic bus(input logic we, input logic [7:0] adr, input logic [31:0] wd,
                      output logic [31:0] rd, output logic ok);
      int n;
      @(posedge clk_i);
      wb_cyc_o <= 1'b1;
      wb_stb_o <= 1'b1;
      wb_we_o  <= we;
      wb_adr_o <= {24'h0, adr};
      wb_sel_o <= 4'hF;
      wb_dat_o <= wd;
      ok = 1'b0;
      rd = 32'h0;
      for (n = 0; n < 40 && !ok; n++) begin
         @(posedge clk_i);
         if (wb_ack_i === 1'b1) begin
            ok = 1'b1;
            rd = wb_dat_i;
         end
      end
      wb_cyc_o <= 1'b0;
      wb_stb_o <= 1'b0;
      wb_we_o  <= 1'b0;
   endtask
endmodule // crs_host_model

// ==== testbench/tb_crs_sched.sv ====
// self-checking bench for the conversion routine scheduler
`include "crs_regs.vh"
// ==========================================================
// bench top
module tb_crs_sched;
   timeunit 1ns;
   timeprecision 1ps;
   localparam int T = 2; // short timebase keeps the run brief
   logic        clk_i, rst_i, fault_override_i, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o, ok;
   logic [31:0] wb_adr_i, wb_dat_i, wb_dat_o, r;
   logic [3:0]  wb_sel_i;
   logic        active_phase_o, balance_enable_o, balance_timer_run_o, ref_regulator_on_o, step_valid_o;
   logic [2:0]  step_o;
   logic [5:0]  seen;
   int          errors, check_count, act_len, pre, s0_len, a2, n;
   logic [31:0] rst_vals [5] = '{`CRS_CTRL_RST, `CRS_TIMING_RST, `CRS_PERIOD_RST, `CRS_STEPCFG_RST, 32'h0};
   crs_sched #(.TICK_CYCLES(T)) crs_sched_inst (.clk_i, .rst_i, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i,
      .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o, .fault_override_i, .active_phase_o, .balance_enable_o,
      .balance_timer_run_o, .ref_regulator_on_o, .step_o, .step_valid_o);
   crs_host_model crs_host_model_inst (.clk_i, .wb_dat_i(wb_dat_o), .wb_ack_i(wb_ack_o), .wb_cyc_o(wb_cyc_i),
      .wb_stb_o(wb_stb_i), .wb_we_o(wb_we_i), .wb_adr_o(wb_adr_i), .wb_sel_o(wb_sel_i), .wb_dat_o(wb_dat_i));
   // ==========================================================
   // helpers
   task automatic report_and_stop;
      $display("comparisons %0d mismatches %0d", check_count, errors);
      if (errors == 0 && check_count > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask
   task automatic tmo(input string what);
      errors++;
      $display("wrong value at %0t: %s timed out", $time, what);
      report_and_stop();
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
      check_count++;
      if (got !== exp) begin
         errors++;
         $display("wrong value at %0t: %s got %h expected %h", $time, what, got, exp);
      end
   endtask
   task automatic ok_if(input logic c, input string what);
      chk({31'h0, c}, 32'h1, what);
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      crs_host_model_inst.bus(1'b1, a, d, r, ok);
      if (ok !== 1'b1) tmo("write");
   endtask
   task automatic rd(input logic [7:0] a);
      crs_host_model_inst.bus(1'b0, a, 32'h0, r, ok);
      if (ok !== 1'b1) tmo("read");
   endtask
   task automatic idle;
      for (n = 0; n < 4000 && active_phase_o !== 1'b0; n++) @(posedge clk_i);
      if (n == 4000) tmo("idle wait");
   endtask
   // one run; bm, tm, rf: expected balance, timer, regulator
   task automatic watch(input logic bm, input logic tm, input logic rf);
      logic [2:0] ps;
      logic       pv;
      act_len = 0;
      pre = -1;
      s0_len = 0;
      seen = 6'h0;
      pv = 1'b0;
      ps = 3'h0;
      for (n = 0; n < 4000 && active_phase_o !== 1'b1; n++) @(posedge clk_i);
      if (n == 4000) tmo("run start");
      while (active_phase_o === 1'b1) begin
         if (step_valid_o === 1'b1) begin
            if (pre < 0) pre = act_len;
            seen[step_o] = 1'b1;
            if (step_o == 3'h0) s0_len++;
            if (pv && ps == step_o) begin
               if (step_o < 3'h2) ok_if(balance_enable_o === bm && balance_timer_run_o === tm, "mand bal");
               if (step_o == 3'h2) ok_if(balance_enable_o === 1'b1, "aux balance");
               if (step_o > 3'h2) ok_if(balance_enable_o === 1'b0, "terminal balance");
               ok_if(ref_regulator_on_o === rf, "regulator in step");
            end
         end
         pv = step_valid_o;
         ps = step_o;
         act_len++;
         if (act_len == 4000) tmo("run end");
         @(posedge clk_i);
      end
   endtask
   // ==========================================================
   // stimulus
   initial begin
      clk_i = 1'b0;
      forever #5 clk_i = ~clk_i;
   end
   initial begin
      rst_i = 1'b1;
      fault_override_i = 1'b0;
      repeat (2) @(posedge clk_i);
      rst_i <= 1'b0;
      for (int i = 0; i < 5; i++) begin
         rd(8'(4 * i));
         chk(r, rst_vals[i], "reset value");
      end
      wr(8'h14, 32'hFFFFFFFF);
      rd(8'h14);
      chk(r, 32'h0, "unmapped place");
      wr(`CRS_ADDR_CTRL, 32'h00000010);
      repeat (2) @(posedge clk_i);
      ok_if(ref_regulator_on_o === 1'b1, "static regulator");
      wr(`CRS_ADDR_CTRL, 32'h00000030);
      repeat (2) @(posedge clk_i);
      ok_if(ref_regulator_on_o === 1'b0, "dynamic regulator idle");
      $display("test 1 done");
      wr(`CRS_ADDR_TIMING, 32'h00040603);
      wr(`CRS_ADDR_STEPCFG, 32'h0000024A);
      wr(`CRS_ADDR_CTRL, 32'h0000007D);
      watch(1'b0, 1'b0, 1'b1);
      a2 = act_len;
      chk({26'h0, seen}, 32'h3F, "steps at count 0");
      ok_if(pre > 3 * T, "settle wait");
      ok_if(s0_len > 2 * T && s0_len <= 3 * T + 2, "on-demand step");
      repeat (2) @(posedge clk_i);
      ok_if(ref_regulator_on_o === 1'b0, "regulator after run");
      rd(`CRS_ADDR_STATUS);
      chk({16'h0, r[31:16]}, 32'h1, "period count");
      $display("test 2 done");
      idle();
      wr(`CRS_ADDR_CTRL, 32'h00000049);
      watch(1'b1, 1'b1, 1'b0);
      chk({26'h0, seen}, 32'h03, "steps at count 1");
      ok_if(pre <= 3, "no settle wait");
      ok_if(a2 > act_len, "phase length");
      rd(`CRS_ADDR_STATUS);
      chk({16'h0, r[31:16]}, 32'h2, "period count");
      $display("test 3 done");
      idle();
      wr(`CRS_ADDR_TIMING, 32'h03040603);
      wr(`CRS_ADDR_PERIOD, 32'h0000003C);
      wr(`CRS_ADDR_CTRL, 32'h00000046);
      watch(1'b0, 1'b1, 1'b0);
      chk({26'h0, seen}, 32'h3B, "steps at count 2");
      ok_if(pre > 3 * T && pre <= 7 * T + 3, "settle and align");
      ok_if(s0_len > 5 * T && s0_len <= 6 * T + 2, "cyclic step");
      a2 = act_len;
      for (n = 0; n < 400 && active_phase_o !== 1'b1; n++) @(posedge clk_i);
      ok_if(a2 + n >= 59 * T && a2 + n <= 61 * T, "idle rest of period");
      watch(1'b0, 1'b1, 1'b0);
      chk({26'h0, seen}, 32'h03, "steps at count 3");
      rd(`CRS_ADDR_STATUS);
      ok_if(r[`CRS_STAT_OVERRUN] === 1'b0, "no overrun");
      wr(`CRS_ADDR_PERIOD, 32'h00000004);
      for (n = 0; n < 50 && r[`CRS_STAT_OVERRUN] !== 1'b1; n++) rd(`CRS_ADDR_STATUS);
      ok_if(r[`CRS_STAT_OVERRUN] === 1'b1, "overrun latch");
      wr(`CRS_ADDR_CTRL, 32'h0);
      idle();
      rd(`CRS_ADDR_STATUS);
      ok_if(r[`CRS_STAT_OVERRUN] === 1'b1, "latch held");
      wr(`CRS_ADDR_STATUS, 32'h00000002);
      rd(`CRS_ADDR_STATUS);
      ok_if(r[`CRS_STAT_OVERRUN] === 1'b0, "latch cleared");
      $display("test 4 done");
      wr(`CRS_ADDR_PERIOD, 32'h0000003C);
      wr(`CRS_ADDR_CTRL, 32'h00000002);
      for (n = 0; n < 2000 && !(step_valid_o === 1'b1 && step_o === 3'h1); n++) @(posedge clk_i);
      if (n == 2000) tmo("stack step");
      fault_override_i <= 1'b1;
      repeat (8) @(posedge clk_i);
      ok_if(active_phase_o === 1'b0 && step_valid_o === 1'b0, "override abort");
      fault_override_i <= 1'b0;
      for (n = 0; n < 300 && active_phase_o !== 1'b1; n++) @(posedge clk_i);
      ok_if(n == 300, "idle after override");
      wr(`CRS_ADDR_CTRL, 32'h0);
      $display("test 5 done");
      report_and_stop();
   end
endmodule // tb_crs_sched
